// file: hdl/current_limit_pkg.sv
// Purpose: Constants and helpers for the two-channel current input limit monitor
// Assumes: Parameter bytes arrive one at a time in record order, high byte of a word first
// Notes: Functional notes below
// Functional notes
// - Byte 00h enables, 40h disables diagnostic interrupts
// - Limit enable bits 0,1 switch channel monitoring
// - Channel 0 rejection: bits 1:0, off/60/50Hz
// - Channel 1 rejection: bits 3:2, same coding
// - Function code FFh switches channel off
// - Codes 31h,41h,30h,40h select range and format
// - Full scale 6C00h or 4000h, bottom zero
// - Limit outside nominal range is parameterization error
// - Upper 7FFFh, lower 8000h disable that limit
// - Limit crossing with monitoring on raises process interrupt
// - Over flags: bit 0 channel 0, bit 1 channel 1
// - Under flags: bit 0 channel 0, bit 1 channel 1
package current_limit_pkg;
    localparam int NUM_CH = 2;

    // ****************************************
    // Parameter record byte positions
    // ****************************************
    localparam logic [3:0] IDX_DIAG = 4'h0;
    localparam logic [3:0] IDX_MONITOR_EN = 4'h2;
    localparam logic [3:0] IDX_REJECT = 4'h3;
    localparam logic [3:0] IDX_FN0 = 4'h4;
    localparam logic [3:0] IDX_UL0_HI = 4'h6;
    localparam logic [3:0] IDX_UL0_LO = 4'h7;
    localparam logic [3:0] IDX_LL0_HI = 4'h8;
    localparam logic [3:0] IDX_LL0_LO = 4'h9;
    localparam logic [3:0] IDX_FN1 = 4'hA;
    localparam logic [3:0] IDX_UL1_HI = 4'hC;
    localparam logic [3:0] IDX_UL1_LO = 4'hD;
    localparam logic [3:0] IDX_LL1_HI = 4'hE;
    localparam logic [3:0] IDX_LL1_LO = 4'hF;

    // ****************************************
    // Codes and reset values
    // ****************************************
    localparam logic [7:0] DIAG_ON = 8'h00;
    localparam logic [7:0] DIAG_OFF = 8'h40;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] FN_A_0_20 = 8'h31;
    localparam logic [7:0] FN_B_0_20 = 8'h41;
    localparam logic [7:0] FN_A_4_20 = 8'h30;
    localparam logic [7:0] FN_B_4_20 = 8'h40;
    localparam logic [7:0] FN_OFF = 8'hFF;
    localparam logic [7:0] RST_FN = 8'h31;
    localparam logic [1:0] REJECT_BAD = 2'b11;
    localparam int REJECT_W = 2;
    localparam logic [15:0] UPPER_OFF = 16'h7FFF;
    localparam logic [15:0] LOWER_OFF = 16'h8000;
    localparam logic [15:0] FULL_A = 16'h6C00;
    localparam logic [15:0] FULL_B = 16'h4000;
    localparam logic [15:0] OVER_A = 16'h7EFF;
    localparam logic [15:0] OVER_B = 16'h5000;
    localparam logic [15:0] UNDER_A = 16'hED00;
    localparam logic [15:0] UNDER_B = 16'hF333;
    localparam logic [15:0] RANGE_BOTTOM = 16'h0000;
    localparam logic [7:0] FLAGS_ZERO = 8'h00;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic fn_valid(input logic [7:0] code);
        return (code == FN_A_0_20) || (code == FN_B_0_20) || (code == FN_A_4_20)
            || (code == FN_B_4_20) || (code == FN_OFF);
    endfunction

    function automatic logic fn_second(input logic [7:0] code);
        return (code == FN_B_0_20) || (code == FN_B_4_20);
    endfunction

    function automatic logic [15:0] fn_full(input logic [7:0] code);
        return fn_second(code) ? FULL_B : FULL_A;
    endfunction

    // A disabled limit is always acceptable; otherwise it must sit in bottom..full scale
    function automatic logic limit_ok(input logic [15:0] value, input logic [15:0] offCode,
                                      input logic [7:0] code);
        return (value == offCode) || (($signed(value) >= $signed(RANGE_BOTTOM))
            && ($signed(value) <= $signed(fn_full(code))));
    endfunction
endpackage

// file: hdl/limit_checker.sv
// Purpose: One channel's comparison of a measured value against its limit words
// Assumes: Sample strobe and value come from logic on sys_clk
// Notes: Hits are registered one-cycle pulses
`timescale 1ns/1ns
module limit_checker
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic sampleValid,
    input wire logic [15:0] sampleValue,
    input wire logic [15:0] upperLimit,
    input wire logic [15:0] lowerLimit,
    input wire logic monitorOn,
    input wire logic active,
    output logic overHit,
    output logic underHit
);
    import current_limit_pkg::*;

    wire logic armed;
    wire logic next_overHit;
    wire logic next_underHit;

    assign armed = sampleValid && monitorOn && active;
    // Disabled codes are excluded explicitly, not just by their extreme value
    assign next_overHit = armed && (upperLimit != UPPER_OFF)
        && ($signed(sampleValue) > $signed(upperLimit));
    assign next_underHit = armed && (lowerLimit != LOWER_OFF)
        && ($signed(sampleValue) < $signed(lowerLimit));

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            overHit <= 1'b0;
            underHit <= 1'b0;
        end else if (clkEn) begin
            overHit <= next_overHit;
            underHit <= next_underHit;
        end
    end

    property p_over_hit;
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && armed && $signed(sampleValue) > $signed(upperLimit)) |=> overHit;
    endproperty
    a_over_hit: assert property (p_over_hit) else $error("upper crossing missed");

    property p_under_hit;
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && armed && $signed(sampleValue) < $signed(lowerLimit)) |=> underHit;
    endproperty
    a_under_hit: assert property (p_under_hit) else $error("lower crossing missed");

    property p_no_hit_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && !(monitorOn && active)) |=> !overHit && !underHit;
    endproperty
    a_no_hit_idle: assert property (p_no_hit_idle) else $error("hit while off");
endmodule

// file: hdl/current_limit_monitor.sv
// Purpose: Parameter bytes and limit monitoring for a two-channel current input
// Assumes: All inputs are on sys_clk; clkEn low freezes every flip-flop
// Notes: Flags are sticky until flagClear; a new hit in the clear cycle survives
`timescale 1ns/1ns
module current_limit_monitor
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic paramWrite,
    input wire logic [3:0] paramIndex,
    input wire logic [7:0] paramData,
    input wire logic [3:0] paramReadIndex,
    output logic [7:0] paramReadData,
    input wire logic [current_limit_pkg::NUM_CH-1:0] sampleValid,
    input wire logic [15:0] sampleValue0,
    input wire logic [15:0] sampleValue1,
    input wire logic flagClear,
    output logic [7:0] limitOverFlags,
    output logic [7:0] limitUnderFlags,
    output logic processIrq,
    output logic diagIrqEnabled,
    output logic paramError,
    output logic [current_limit_pkg::NUM_CH-1:0] channelActive,
    output logic [current_limit_pkg::NUM_CH-1:0] formatSecond,
    output logic [1:0] mainsReject0,
    output logic [1:0] mainsReject1,
    output logic [15:0] fullScale0,
    output logic [15:0] fullScale1,
    output logic [15:0] overrangeTop0,
    output logic [15:0] overrangeTop1,
    output logic [15:0] underrangeBottom0,
    output logic [15:0] underrangeBottom1
);
    import current_limit_pkg::*;

    // ****************************************
    // Parameter storage
    // ****************************************
    logic [7:0] diag_irq_enable;
    logic [7:0] limit_monitor_enable;
    logic [7:0] mains_reject_select;
    logic [7:0] channel_function_code [NUM_CH];
    logic [15:0] channel_upper_limit [NUM_CH];
    logic [15:0] channel_lower_limit [NUM_CH];

    wire logic [3:0] idxFn [NUM_CH];
    wire logic [3:0] idxUlHi [NUM_CH];
    wire logic [3:0] idxUlLo [NUM_CH];
    wire logic [3:0] idxLlHi [NUM_CH];
    wire logic [3:0] idxLlLo [NUM_CH];
    assign idxFn[0] = IDX_FN0;
    assign idxFn[1] = IDX_FN1;
    assign idxUlHi[0] = IDX_UL0_HI;
    assign idxUlHi[1] = IDX_UL1_HI;
    assign idxUlLo[0] = IDX_UL0_LO;
    assign idxUlLo[1] = IDX_UL1_LO;
    assign idxLlHi[0] = IDX_LL0_HI;
    assign idxLlHi[1] = IDX_LL1_HI;
    assign idxLlLo[0] = IDX_LL0_LO;
    assign idxLlLo[1] = IDX_LL1_LO;

    wire logic wrDiag;
    wire logic wrMonitorEn;
    wire logic wrReject;
    assign wrDiag = paramWrite && (paramIndex == IDX_DIAG);
    assign wrMonitorEn = paramWrite && (paramIndex == IDX_MONITOR_EN);
    assign wrReject = paramWrite && (paramIndex == IDX_REJECT);

    // Record ordering during stop is up to the master; bytes are taken whenever written
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            diag_irq_enable <= DIAG_ON;
            limit_monitor_enable <= BYTE_ZERO;
            mains_reject_select <= BYTE_ZERO;
        end else if (clkEn) begin
            if (wrDiag) begin
                diag_irq_enable <= paramData;
            end
            if (wrMonitorEn) begin
                limit_monitor_enable <= paramData;
            end
            if (wrReject) begin
                mains_reject_select <= paramData;
            end
        end
    end

    // ****************************************
    // Per-channel words and checkers
    // ****************************************
    wire logic [15:0] sampleValue [NUM_CH];
    wire logic [NUM_CH-1:0] overHit;
    wire logic [NUM_CH-1:0] underHit;
    wire logic [NUM_CH-1:0] chanOn;
    wire logic [NUM_CH-1:0] chanBad;
    wire logic [1:0] rejectCode [NUM_CH];
    assign sampleValue[0] = sampleValue0;
    assign sampleValue[1] = sampleValue1;

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        wire logic [7:0] fn;
        assign fn = channel_function_code[ch];
        assign chanOn[ch] = fn_valid(fn) && (fn != FN_OFF);
        assign rejectCode[ch] = mains_reject_select[ch*REJECT_W +: REJECT_W];
        assign chanBad[ch] = !fn_valid(fn) || (rejectCode[ch] == REJECT_BAD)
            || (chanOn[ch] && !limit_ok(channel_upper_limit[ch], UPPER_OFF, fn))
            || (chanOn[ch] && !limit_ok(channel_lower_limit[ch], LOWER_OFF, fn));

        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                channel_function_code[ch] <= RST_FN;
                channel_upper_limit[ch] <= UPPER_OFF;
                channel_lower_limit[ch] <= LOWER_OFF;
            end else if (clkEn && paramWrite) begin
                if (paramIndex == idxFn[ch]) begin
                    channel_function_code[ch] <= paramData;
                end
                if (paramIndex == idxUlHi[ch]) begin
                    channel_upper_limit[ch][15:8] <= paramData;
                end
                if (paramIndex == idxUlLo[ch]) begin
                    channel_upper_limit[ch][7:0] <= paramData;
                end
                if (paramIndex == idxLlHi[ch]) begin
                    channel_lower_limit[ch][15:8] <= paramData;
                end
                if (paramIndex == idxLlLo[ch]) begin
                    channel_lower_limit[ch][7:0] <= paramData;
                end
            end
        end

        limit_checker u_check (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .clkEn(clkEn),
            .sampleValid(sampleValid[ch]),
            .sampleValue(sampleValue[ch]),
            .upperLimit(channel_upper_limit[ch]),
            .lowerLimit(channel_lower_limit[ch]),
            .monitorOn(limit_monitor_enable[ch]),
            .active(chanOn[ch]),
            .overHit(overHit[ch]),
            .underHit(underHit[ch])
        );
    end

    // ****************************************
    // Status, flags and readback
    // ****************************************
    wire logic next_paramError;
    wire logic [7:0] next_limitOverFlags;
    wire logic [7:0] next_limitUnderFlags;
    wire logic [7:0] readMux;
    wire logic [7:0] hitOverByte;
    wire logic [7:0] hitUnderByte;

    // Any diag byte other than the two listed codes is refused as a setup error
    assign next_paramError = |chanBad
        || ((diag_irq_enable != DIAG_ON) && (diag_irq_enable != DIAG_OFF));
    assign hitOverByte = {{(8-NUM_CH){1'b0}}, overHit};
    assign hitUnderByte = {{(8-NUM_CH){1'b0}}, underHit};
    // Set wins over clear so a crossing in the acknowledge cycle is kept
    assign next_limitOverFlags = (flagClear ? FLAGS_ZERO : limitOverFlags) | hitOverByte;
    assign next_limitUnderFlags = (flagClear ? FLAGS_ZERO : limitUnderFlags) | hitUnderByte;

    assign readMux =
        (paramReadIndex == IDX_DIAG) ? diag_irq_enable :
        (paramReadIndex == IDX_MONITOR_EN) ? limit_monitor_enable :
        (paramReadIndex == IDX_REJECT) ? mains_reject_select :
        (paramReadIndex == IDX_FN0) ? channel_function_code[0] :
        (paramReadIndex == IDX_UL0_HI) ? channel_upper_limit[0][15:8] :
        (paramReadIndex == IDX_UL0_LO) ? channel_upper_limit[0][7:0] :
        (paramReadIndex == IDX_LL0_HI) ? channel_lower_limit[0][15:8] :
        (paramReadIndex == IDX_LL0_LO) ? channel_lower_limit[0][7:0] :
        (paramReadIndex == IDX_FN1) ? channel_function_code[1] :
        (paramReadIndex == IDX_UL1_HI) ? channel_upper_limit[1][15:8] :
        (paramReadIndex == IDX_UL1_LO) ? channel_upper_limit[1][7:0] :
        (paramReadIndex == IDX_LL1_HI) ? channel_lower_limit[1][15:8] :
        (paramReadIndex == IDX_LL1_LO) ? channel_lower_limit[1][7:0] : BYTE_ZERO;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            limitOverFlags <= FLAGS_ZERO;
            limitUnderFlags <= FLAGS_ZERO;
            processIrq <= 1'b0;
            diagIrqEnabled <= 1'b0;
            paramError <= 1'b0;
            paramReadData <= BYTE_ZERO;
        end else if (clkEn) begin
            limitOverFlags <= next_limitOverFlags;
            limitUnderFlags <= next_limitUnderFlags;
            processIrq <= |{overHit, underHit};
            diagIrqEnabled <= (diag_irq_enable == DIAG_ON);
            paramError <= next_paramError;
            paramReadData <= readMux;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            channelActive <= '0;
            formatSecond <= '0;
            mainsReject0 <= '0;
            mainsReject1 <= '0;
            fullScale0 <= FULL_A;
            fullScale1 <= FULL_A;
            overrangeTop0 <= OVER_A;
            overrangeTop1 <= OVER_A;
            underrangeBottom0 <= UNDER_A;
            underrangeBottom1 <= UNDER_A;
        end else if (clkEn) begin
            channelActive <= chanOn;
            formatSecond[0] <= fn_second(channel_function_code[0]);
            formatSecond[1] <= fn_second(channel_function_code[1]);
            mainsReject0 <= rejectCode[0];
            mainsReject1 <= rejectCode[1];
            fullScale0 <= fn_full(channel_function_code[0]);
            fullScale1 <= fn_full(channel_function_code[1]);
            overrangeTop0 <= fn_second(channel_function_code[0]) ? OVER_B : OVER_A;
            overrangeTop1 <= fn_second(channel_function_code[1]) ? OVER_B : OVER_A;
            underrangeBottom0 <= fn_second(channel_function_code[0]) ? UNDER_B : UNDER_A;
            underrangeBottom1 <= fn_second(channel_function_code[1]) ? UNDER_B : UNDER_A;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_diag;
        @(posedge sys_clk) disable iff (sys_rst)
        clkEn |=> diagIrqEnabled == ($past(diag_irq_enable) == DIAG_ON);
    endproperty
    a_diag: assert property (p_diag) else $error("diag enable wrong");

    property p_irq_two;
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && sampleValid[0] && chanOn[0] && limit_monitor_enable[0]
            && channel_upper_limit[0] != UPPER_OFF
            && $signed(sampleValue0) > $signed(channel_upper_limit[0])) ##1 clkEn
        |=> processIrq && limitOverFlags[0];
    endproperty
    a_irq_two: assert property (p_irq_two) else $error("irq not raised");

    property p_flag_set_wins;
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && flagClear && underHit[1]) |=> limitUnderFlags[1];
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag lost");

    property p_flag_clear;
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && flagClear && !overHit[0]) |=> !limitOverFlags[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_reserved_flags;
        @(posedge sys_clk) disable iff (sys_rst)
        limitOverFlags[7:NUM_CH] == '0 && limitUnderFlags[7:NUM_CH] == '0;
    endproperty
    a_reserved_flags: assert property (p_reserved_flags) else $error("reserved set");

    property p_off_channel;
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && channel_function_code[1] == FN_OFF) |=> !channelActive[1];
    endproperty
    a_off_channel: assert property (p_off_channel) else $error("off channel active");

    property p_bad_reject;
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && mains_reject_select[3:2] == REJECT_BAD) |=> paramError;
    endproperty
    a_bad_reject: assert property (p_bad_reject) else $error("bad reject accepted");

    property p_limit_range;
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && chanOn[0] && channel_upper_limit[0] != UPPER_OFF
            && $signed(channel_upper_limit[0]) > $signed(fn_full(channel_function_code[0])))
        |=> paramError;
    endproperty
    a_limit_range: assert property (p_limit_range) else $error("limit not refused");

    property p_full_scale;
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && channel_function_code[0] == FN_B_4_20) |=> fullScale0 == FULL_B;
    endproperty
    a_full_scale: assert property (p_full_scale) else $error("full scale wrong");
endmodule

// file: test/param_master.sv
// Purpose: Parameter master that writes record bytes into the monitor
// Assumes: Tasks are entered just after a rising sys_clk edge
// Notes: Released lines carry inverted data so a stale byte never looks live
`timescale 1ns/1ns
module param_master
(
    input wire logic sys_clk,
    input wire logic stopped,
    output logic paramWrite,
    output logic [3:0] paramIndex,
    output logic [7:0] paramData
);
    initial begin
        paramWrite = 1'b0;
        paramIndex = 4'h0;
        paramData = 8'h00;
    end

    task automatic write_byte(input logic [3:0] idx, input logic [7:0] data);
        // First record bytes are only sent while the system is stopped
        if ((idx <= 4'h2) && !stopped) begin
            return;
        end
        @(posedge sys_clk);
        #1;
        paramWrite = 1'b1;
        paramIndex = idx;
        paramData = data;
        @(posedge sys_clk);
        #1;
        paramWrite = 1'b0;
        paramIndex = ~idx;
        paramData = ~data;
    endtask

    // High byte goes to the lower position
    task automatic write_word(input logic [3:0] idx, input logic [15:0] word);
        write_byte(idx, word[15:8]);
        write_byte(idx + 4'h1, word[7:0]);
    endtask
endmodule

// file: test/current_limit_monitor_test.sv
// Purpose: Self-checking bench for the two-channel current limit monitor
// Assumes: Stimulus changes 1 ns after a rising sys_clk edge
// Notes: Flags show two edges after a sample, derived outputs one edge after a write
`timescale 1ns/1ns
module current_limit_monitor_test;
    import current_limit_pkg::*;

    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic stopped = 1'b1;
    logic [3:0] paramReadIndex = 4'h0;
    logic [1:0] sampleValid = 2'b00;
    logic [15:0] sampleValue0 = 16'h0000;
    logic [15:0] sampleValue1 = 16'h0000;
    logic flagClear = 1'b0;
    logic paramWrite, processIrq, diagIrqEnabled, paramError;
    logic [3:0] paramIndex;
    logic [7:0] paramData, paramReadData, limitOverFlags, limitUnderFlags;
    logic [1:0] channelActive, formatSecond, mainsReject0, mainsReject1;
    logic [15:0] fullScale0, fullScale1, overTop0, overTop1, underBot0, underBot1;
    int failCount = 0;
    int comparisons = 0;

    always #25 sys_clk = ~sys_clk;

    param_master u_master (
        .sys_clk(sys_clk), .stopped(stopped), .paramWrite(paramWrite),
        .paramIndex(paramIndex), .paramData(paramData)
    );
    current_limit_monitor u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .paramWrite(paramWrite),
        .paramIndex(paramIndex), .paramData(paramData), .paramReadIndex(paramReadIndex),
        .paramReadData(paramReadData), .sampleValid(sampleValid),
        .sampleValue0(sampleValue0), .sampleValue1(sampleValue1), .flagClear(flagClear),
        .limitOverFlags(limitOverFlags), .limitUnderFlags(limitUnderFlags),
        .processIrq(processIrq), .diagIrqEnabled(diagIrqEnabled), .paramError(paramError),
        .channelActive(channelActive), .formatSecond(formatSecond),
        .mainsReject0(mainsReject0), .mainsReject1(mainsReject1),
        .fullScale0(fullScale0), .fullScale1(fullScale1),
        .overrangeTop0(overTop0), .overrangeTop1(overTop1),
        .underrangeBottom0(underBot0), .underrangeBottom1(underBot1)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic finalReport;
        if ((failCount == 0) && (comparisons > 0)) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failCount++;
            $display("Error at %0t ns: seen %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        logic [3:0] idx [7] = '{IDX_DIAG, IDX_FN0, IDX_UL0_HI, IDX_UL0_LO, IDX_LL0_HI,
                                IDX_LL0_LO, IDX_FN1};
        logic [7:0] exp [7] = '{8'h00, 8'h31, 8'h7F, 8'hFF, 8'h80, 8'h00, 8'h31};
        sys_rst = 1'b1;
        tick(10);
        sys_rst = 1'b0;
        tick(1);
        check(16'(diagIrqEnabled), 16'h0001);
        check(16'(channelActive), 16'h0003);
        check(16'(paramError), 16'h0000);
        check({limitOverFlags, limitUnderFlags}, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            paramReadIndex = idx[i];
            tick(1);
            check(16'(paramReadData), 16'(exp[i]));
        end
    endtask

    task automatic t_diag;
        u_master.write_byte(IDX_DIAG, 8'h40);
        tick(1);
        check(16'(diagIrqEnabled), 16'h0000);
        check(16'(paramError), 16'h0000);
        // A frozen clock enable must drop the write
        clkEn = 1'b0;
        u_master.write_byte(IDX_DIAG, 8'h00);
        clkEn = 1'b1;
        tick(1);
        check(16'(diagIrqEnabled), 16'h0000);
        u_master.write_byte(IDX_DIAG, 8'h00);
        tick(1);
        check(16'(diagIrqEnabled), 16'h0001);
    endtask

    task automatic t_reject;
        logic [7:0] v [5] = '{8'h09, 8'hF6, 8'h00, 8'h03, 8'h0C};
        for (int i = 0; i < 5; i++) begin
            u_master.write_byte(IDX_REJECT, v[i]);
            paramReadIndex = IDX_REJECT;
            tick(1);
            check(16'(mainsReject0), 16'(v[i][1:0]));
            check(16'(mainsReject1), 16'(v[i][3:2]));
            check(16'(paramError), 16'((v[i][1:0] == 2'b11) || (v[i][3:2] == 2'b11)));
            check(16'(paramReadData), 16'(v[i]));
        end
        u_master.write_byte(IDX_REJECT, 8'h00);
    endtask

    task automatic t_function;
        logic [7:0] code [6] = '{FN_A_0_20, FN_B_0_20, FN_A_4_20, FN_B_4_20, FN_OFF, 8'h22};
        logic sec;
        for (int i = 0; i < 6; i++) begin
            sec = (i == 1) || (i == 3);
            u_master.write_byte(IDX_FN0, code[i]);
            u_master.write_byte(IDX_FN1, code[i]);
            tick(1);
            check(16'(channelActive[0]), 16'(i < 4));
            check(16'(formatSecond[0]), 16'(sec));
            check(fullScale0, sec ? 16'h4000 : 16'h6C00);
            check(overTop0, sec ? 16'h5000 : 16'h7EFF);
            check(underBot0, sec ? 16'hF333 : 16'hED00);
            check(16'(paramError), 16'(i == 5));
            check(16'({channelActive[1], formatSecond[1]}), 16'({i < 4, sec}));
            check(fullScale1, sec ? 16'h4000 : 16'h6C00);
            check(overTop1, sec ? 16'h5000 : 16'h7EFF);
            check(underBot1, sec ? 16'hF333 : 16'hED00);
        end
        u_master.write_byte(IDX_FN1, FN_A_0_20);
    endtask

    task automatic t_limits;
        logic [15:0] ul [6] = '{16'h6C01, 16'h6C00, 16'h7FFF, 16'h7FFF, 16'h6C00, 16'h4000};
        logic [15:0] ll [6] = '{16'h8000, 16'h8000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
        logic [5:0] err = 6'b010101;
        for (int i = 0; i < 6; i++) begin
            u_master.write_byte(IDX_FN0, (i < 4) ? FN_A_0_20 : FN_B_0_20);
            u_master.write_word(IDX_UL0_HI, ul[i]);
            u_master.write_word(IDX_LL0_HI, ll[i]);
            tick(1);
            check(16'(paramError), 16'(err[i]));
        end
    endtask

    task automatic sample(input logic ch, input logic [15:0] val, input logic [7:0] over,
                          input logic [7:0] under);
        sampleValid = ch ? 2'b10 : 2'b01;
        sampleValue0 = ch ? ~val : val;
        sampleValue1 = ch ? val : ~val;
        tick(1);
        sampleValid = 2'b00;
        tick(1);
        check(16'(processIrq), 16'((over | under) != 8'h00));
        check({limitOverFlags, limitUnderFlags}, {over, under});
        tick(1);
        check(16'(processIrq), 16'h0000);
        check({limitOverFlags, limitUnderFlags}, {over, under});
        flagClear = 1'b1;
        tick(1);
        flagClear = 1'b0;
        check({limitOverFlags, limitUnderFlags}, 16'h0000);
    endtask

    task automatic t_monitor;
        u_master.write_byte(IDX_FN0, FN_A_0_20);
        u_master.write_byte(IDX_MONITOR_EN, 8'h01);
        u_master.write_word(IDX_UL0_HI, 16'h6000);
        u_master.write_word(IDX_LL0_HI, 16'h1000);
        tick(1);
        check(16'(paramError), 16'h0000);
        sample(1'b0, 16'h7000, 8'h01, 8'h00);
        sample(1'b0, 16'h6000, 8'h00, 8'h00);
        sample(1'b0, 16'h0FFF, 8'h00, 8'h01);
        sample(1'b0, 16'h8001, 8'h00, 8'h01);
        sample(1'b0, 16'h1000, 8'h00, 8'h00);
        sample(1'b1, 16'h7000, 8'h00, 8'h00);
        u_master.write_byte(IDX_MONITOR_EN, 8'h02);
        u_master.write_word(IDX_UL1_HI, 16'h6000);
        u_master.write_word(IDX_LL1_HI, 16'h1000);
        tick(1);
        sample(1'b0, 16'h7000, 8'h00, 8'h00);
        sample(1'b1, 16'h7001, 8'h02, 8'h00);
        sample(1'b1, 16'h0000, 8'h00, 8'h02);
        // Clear lands in the hit cycle: the new flag must survive
        sampleValid = 2'b10;
        tick(1);
        sampleValid = 2'b00;
        flagClear = 1'b1;
        tick(1);
        flagClear = 1'b0;
        check({limitOverFlags, limitUnderFlags}, 16'h0002);
        flagClear = 1'b1;
        tick(1);
        flagClear = 1'b0;
        check({limitOverFlags, limitUnderFlags}, 16'h0000);
        u_master.write_byte(IDX_FN1, FN_OFF);
        tick(1);
        sample(1'b1, 16'h7000, 8'h00, 8'h00);
    endtask

    initial begin
        t_reset();
        t_diag();
        t_reject();
        t_function();
        t_limits();
        t_monitor();
        t_reset();
        finalReport();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        failCount++;
        finalReport();
    end
endmodule
